// *** hdl/cose_pkg.sv ***
// shared constants for the or / stack instruction execution block
package cose_pkg;

  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_IDLE_INSTRUCTION = 8'hFF;
  localparam logic [7:0] OP_OR_RR            = 8'h42;
  localparam logic [7:0] OP_OR_RIR           = 8'h43;
  localparam logic [7:0] OP_OR_REG_REG       = 8'h44;
  localparam logic [7:0] OP_OR_REG_IND       = 8'h45;
  localparam logic [7:0] OP_OR_REG_LIT       = 8'h46;
  localparam logic [7:0] OP_STACK_READ_REG   = 8'h50;
  localparam logic [7:0] OP_STACK_READ_IND   = 8'h51;
  localparam logic [7:0] OP_STACK_WRITE_REG  = 8'h70;
  localparam logic [7:0] OP_STACK_WRITE_IND  = 8'h71;
  localparam logic [7:0] OP_USER_READ_DESC   = 8'h92;
  localparam logic [7:0] OP_USER_READ_ASC    = 8'h93;
  localparam logic [7:0] OP_USER_WRITE_DESC  = 8'h82;

  // ---------------------------------------------------------------
  // cycle counts
  // ---------------------------------------------------------------
  localparam logic [3:0] CYC_4 = 4'h4;
  localparam logic [3:0] CYC_6 = 4'h6;
  localparam logic [3:0] CYC_8 = 4'h8;
  // cycle of the run phase that performs the operation
  localparam logic [3:0] STEP_EXEC = 4'h0;
  // cycle at which stack memory read data is valid (one-cycle ram latency)
  localparam logic [3:0] STEP_POP_DATA = 4'h2;

  // ---------------------------------------------------------------
  // register file map
  // ---------------------------------------------------------------
  localparam int unsigned RF_DEPTH = 256;
  localparam logic [7:0] IDX_STACK_POINTER_HIGH = 8'hD8;
  localparam logic [7:0] IDX_STACK_POINTER_LOW  = 8'hD9;
  localparam logic [7:0] IDX_FLAGS              = 8'hD5;
  localparam logic [3:0] WORK_BASE_HI           = 4'hC;
  localparam logic [7:0] RF_RESET               = 8'h00;

  // ---------------------------------------------------------------
  // flag bit positions inside the flags register
  // ---------------------------------------------------------------
  localparam int unsigned FLAG_CARRY    = 7;
  localparam int unsigned FLAG_ZERO     = 6;
  localparam int unsigned FLAG_SIGN     = 5;
  localparam int unsigned FLAG_OVERFLOW = 4;
  localparam int unsigned RESULT_MSB    = 7;

  typedef enum logic [0:0] {
    COSE_IDLE,
    COSE_RUN
  } cose_state_e;

endpackage : cose_pkg

// *** hdl/cose_exec.sv ***
// execution of the idle, or, stack and user-stack instruction group
//
// Notes on behaviour
// - opcode FF: one byte, four cycles, changes nothing at all
// - or writes destination OR source into destination; source untouched
// - or sets zero and sign from result, clears overflow, keeps others
// - 42 working regs 4 cycles; 43 indirect working source 6 cycles
// - 44 and 45 source byte first; 46 destination then literal; 6 cycles
// - stack read loads byte at pointer then increments; 50/51, 8 cycles
// - stack pointer high at D8, low at D9, both read/write
// - stack and user-stack moves leave every flag unchanged
// - stack write decrements pointer then stores source; 70/71, 8 cycles
// - stack pointer wraps modulo 16 bits, 0000 minus one is FFFF
// - 92 loads via source pointer, then decrements that pointer, 8 cycles
// - 93 loads via source pointer, then increments that pointer, 8 cycles
// - 82 decrements destination pointer, then stores source there, 8 cycles
`timescale 1ns/10ps
`default_nettype none

module cose_exec (
  input  wire logic        core_clk,          // core clock
  input  wire logic        rst_b,             // async reset, active low
  input  wire logic        clk_en,            // freezes all state while low
  input  wire logic        instr_valid,       // instruction offered
  output logic             instr_ready,       // ready to take an instruction this cycle
  input  wire logic [7:0]  instr_opcode,      // opcode byte
  input  wire logic [7:0]  instr_byte1,       // second instruction byte
  input  wire logic [7:0]  instr_byte2,       // third instruction byte
  output logic             instr_done,        // last cycle of an instruction
  output logic             exec_busy,         // instruction in progress
  output logic [15:0]      mem_addr,          // stack memory address
  output logic [7:0]       mem_wdata,         // stack memory write data
  output logic             mem_we,            // stack memory write strobe
  output logic             mem_re,            // stack memory read strobe
  input  wire logic [7:0]  mem_rdata,         // read data, one cycle after mem_re
  input  wire logic [7:0]  avs_address,       // word address = register index
  input  wire logic        avs_read,          // avalon read
  input  wire logic        avs_write,         // avalon write
  input  wire logic [31:0] avs_writedata,     // avalon write data
  input  wire logic [3:0]  avs_byteenable,    // avalon byte enables
  output logic [31:0]      avs_readdata,      // avalon read data
  output logic             avs_waitrequest    // avalon wait request
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]          rf_mem [cose_pkg::RF_DEPTH];
  cose_pkg::cose_state_e state_reg;
  logic [3:0]          step_reg;
  logic [3:0]          len_reg;
  logic [7:0]          op_reg;
  logic [7:0]          b1_reg;
  logic [7:0]          b2_reg;
  logic                bus_ack_reg;
  logic [7:0]          rdata_reg;
  logic [15:0]         mem_addr_reg;
  logic [7:0]          mem_wdata_reg;
  logic                mem_we_reg;
  logic                mem_re_reg;

  logic                take;
  logic                bus_req;
  logic                bus_go;
  logic [3:0]          len_next;
  logic [7:0]          or_dst;
  logic [7:0]          or_src;
  logic [7:0]          or_res;
  logic                is_or;
  logic [15:0]         sp_cur;
  logic [15:0]         sp_dec;
  logic [15:0]         sp_inc;
  logic [7:0]          push_src;
  logic [7:0]          pop_dst;
  logic [7:0]          up_ptr;
  logic [7:0]          up_dec;
  logic [7:0]          up_inc;
  logic                exec_now;
  logic                pop_now;

  function automatic logic [7:0] work_addr(input logic [3:0] n);
    work_addr = {cose_pkg::WORK_BASE_HI, n};
  endfunction : work_addr

  // ---------------------------------------------------------------
  // handshakes
  // ---------------------------------------------------------------
  // bus accesses are only served between instructions, so the register
  // file never sees a software write in the middle of an operation
  assign bus_req         = avs_read | avs_write;
  assign bus_go          = bus_req & (state_reg == cose_pkg::COSE_IDLE) & ~bus_ack_reg;
  assign avs_waitrequest = bus_req & ~bus_ack_reg;
  assign avs_readdata    = {24'h000000, rdata_reg};
  assign instr_ready     = (state_reg == cose_pkg::COSE_IDLE) & ~bus_req;
  assign take            = instr_valid & instr_ready & clk_en;
  assign exec_busy       = (state_reg == cose_pkg::COSE_RUN);
  assign instr_done      = exec_busy & (step_reg == len_reg - 4'h1);
  assign exec_now        = exec_busy & (step_reg == cose_pkg::STEP_EXEC);
  assign pop_now         = exec_busy & (step_reg == cose_pkg::STEP_POP_DATA);
  assign mem_addr        = mem_addr_reg;
  assign mem_wdata       = mem_wdata_reg;
  assign mem_we          = mem_we_reg;
  assign mem_re          = mem_re_reg;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  always_comb begin
    case (instr_opcode)
      cose_pkg::OP_IDLE_INSTRUCTION: len_next = cose_pkg::CYC_4;
      cose_pkg::OP_OR_RR:            len_next = cose_pkg::CYC_4;
      cose_pkg::OP_OR_RIR:           len_next = cose_pkg::CYC_6;
      cose_pkg::OP_OR_REG_REG,
      cose_pkg::OP_OR_REG_IND,
      cose_pkg::OP_OR_REG_LIT:       len_next = cose_pkg::CYC_6;
      cose_pkg::OP_STACK_READ_REG,
      cose_pkg::OP_STACK_READ_IND:   len_next = cose_pkg::CYC_8;
      cose_pkg::OP_STACK_WRITE_REG,
      cose_pkg::OP_STACK_WRITE_IND:  len_next = cose_pkg::CYC_8;
      cose_pkg::OP_USER_READ_DESC:   len_next = cose_pkg::CYC_8;
      cose_pkg::OP_USER_READ_ASC:    len_next = cose_pkg::CYC_8;
      cose_pkg::OP_USER_WRITE_DESC:  len_next = cose_pkg::CYC_8;
      // opcodes outside this group run as four idle cycles with no effect
      default:                       len_next = cose_pkg::CYC_4;
    endcase
  end

  // or operand selection
  always_comb begin
    is_or  = 1'b1;
    or_dst = 8'h00;
    or_src = 8'h00;
    case (op_reg)
      cose_pkg::OP_OR_RR: begin
        or_dst = work_addr(b1_reg[7:4]);
        or_src = rf_mem[work_addr(b1_reg[3:0])];
      end
      cose_pkg::OP_OR_RIR: begin
        or_dst = work_addr(b1_reg[7:4]);
        or_src = rf_mem[rf_mem[work_addr(b1_reg[3:0])]];
      end
      cose_pkg::OP_OR_REG_REG: begin
        or_dst = b2_reg;
        or_src = rf_mem[b1_reg];
      end
      cose_pkg::OP_OR_REG_IND: begin
        or_dst = b2_reg;
        or_src = rf_mem[rf_mem[b1_reg]];
      end
      cose_pkg::OP_OR_REG_LIT: begin
        or_dst = b1_reg;
        or_src = b2_reg;
      end
      default: is_or = 1'b0;
    endcase
  end

  assign or_res = rf_mem[or_dst] | or_src;

  // stack pointer arithmetic, 16-bit modulo
  assign sp_cur   = {rf_mem[cose_pkg::IDX_STACK_POINTER_HIGH],
                     rf_mem[cose_pkg::IDX_STACK_POINTER_LOW]};
  assign sp_dec   = sp_cur - 16'h0001;
  assign sp_inc   = sp_cur + 16'h0001;
  assign push_src = (op_reg == cose_pkg::OP_STACK_WRITE_IND) ? rf_mem[rf_mem[b1_reg]]
                                                             : rf_mem[b1_reg];
  assign pop_dst  = (op_reg == cose_pkg::OP_STACK_READ_IND) ? rf_mem[b1_reg] : b1_reg;

  // user stack pointer always sits in the first operand byte
  assign up_ptr = rf_mem[b1_reg];
  assign up_dec = up_ptr - 8'h01;
  assign up_inc = up_ptr + 8'h01;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= cose_pkg::COSE_IDLE;
      step_reg  <= 4'h0;
      len_reg   <= cose_pkg::CYC_4;
      op_reg    <= cose_pkg::OP_IDLE_INSTRUCTION;
      b1_reg    <= 8'h00;
      b2_reg    <= 8'h00;
    end else if (clk_en) begin
      case (state_reg)
        cose_pkg::COSE_IDLE: begin
          if (take) begin
            state_reg <= cose_pkg::COSE_RUN;
            step_reg  <= 4'h0;
            len_reg   <= len_next;
            op_reg    <= instr_opcode;
            b1_reg    <= instr_byte1;
            b2_reg    <= instr_byte2;
          end
        end
        cose_pkg::COSE_RUN: begin
          if (instr_done) begin
            state_reg <= cose_pkg::COSE_IDLE;
          end
          step_reg <= step_reg + 4'h1;
        end
        default: state_reg <= cose_pkg::COSE_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // avalon slave: one wait cycle when idle, then registered answer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_ack_reg <= 1'b0;
      rdata_reg   <= 8'h00;
    end else if (clk_en) begin
      bus_ack_reg <= bus_go;
      if (bus_go) begin
        rdata_reg <= rf_mem[avs_address];
      end
    end
  end

  // ---------------------------------------------------------------
  // stack memory port
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_addr_reg  <= 16'h0000;
      mem_wdata_reg <= 8'h00;
      mem_we_reg    <= 1'b0;
      mem_re_reg    <= 1'b0;
    end else if (clk_en) begin
      mem_we_reg <= 1'b0;
      mem_re_reg <= 1'b0;
      if (exec_now) begin
        case (op_reg)
          cose_pkg::OP_STACK_READ_REG,
          cose_pkg::OP_STACK_READ_IND: begin
            mem_addr_reg <= sp_cur;
            mem_re_reg   <= 1'b1;
          end
          cose_pkg::OP_STACK_WRITE_REG,
          cose_pkg::OP_STACK_WRITE_IND: begin
            mem_addr_reg  <= sp_dec;
            mem_wdata_reg <= push_src;
            mem_we_reg    <= 1'b1;
          end
          default: mem_addr_reg <= mem_addr_reg;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // register file; later assignments win, which gives the documented
  // order when a pointer and a data target are the same register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < cose_pkg::RF_DEPTH; i++) begin
        rf_mem[i] <= cose_pkg::RF_RESET;
      end
    end else if (clk_en) begin
      // the write lands at the edge where the master sees waitrequest low
      if (bus_req && bus_ack_reg && avs_write && avs_byteenable[0]) begin
        rf_mem[avs_address] <= avs_writedata[7:0];
      end
      if (exec_now) begin
        if (is_or) begin
          rf_mem[or_dst] <= or_res;
          rf_mem[cose_pkg::IDX_FLAGS][cose_pkg::FLAG_ZERO]     <= (or_res == 8'h00);
          rf_mem[cose_pkg::IDX_FLAGS][cose_pkg::FLAG_SIGN]     <= or_res[cose_pkg::RESULT_MSB];
          rf_mem[cose_pkg::IDX_FLAGS][cose_pkg::FLAG_OVERFLOW] <= 1'b0;
        end
        case (op_reg)
          cose_pkg::OP_STACK_WRITE_REG,
          cose_pkg::OP_STACK_WRITE_IND: begin
            rf_mem[cose_pkg::IDX_STACK_POINTER_HIGH] <= sp_dec[15:8];
            rf_mem[cose_pkg::IDX_STACK_POINTER_LOW]  <= sp_dec[7:0];
          end
          cose_pkg::OP_USER_READ_DESC: begin
            rf_mem[b2_reg] <= rf_mem[up_ptr];
            rf_mem[b1_reg] <= up_dec;
          end
          cose_pkg::OP_USER_READ_ASC: begin
            rf_mem[b2_reg] <= rf_mem[up_ptr];
            rf_mem[b1_reg] <= up_inc;
          end
          cose_pkg::OP_USER_WRITE_DESC: begin
            rf_mem[b1_reg] <= up_dec;
            rf_mem[up_dec] <= rf_mem[b2_reg];
          end
          default: ;
        endcase
      end
      if (pop_now && (op_reg == cose_pkg::OP_STACK_READ_REG ||
                      op_reg == cose_pkg::OP_STACK_READ_IND)) begin
        rf_mem[pop_dst] <= mem_rdata;
        rf_mem[cose_pkg::IDX_STACK_POINTER_HIGH] <= sp_inc[15:8];
        rf_mem[cose_pkg::IDX_STACK_POINTER_LOW]  <= sp_inc[7:0];
      end
    end
  end

endmodule : cose_exec

`default_nettype wire

// *** bench/cose_exec_chk.sv ***
// concurrent checks on the execution block ports
`timescale 1ns/10ps
`default_nettype none

module cose_exec_chk (
  input wire logic        core_clk,       // clock
  input wire logic        rst_b,          // reset, active low
  input wire logic        clk_en,         // run enable
  input wire logic        instr_valid,    // offer
  input wire logic        instr_ready,    // take
  input wire logic [7:0]  instr_opcode,   // opcode
  input wire logic        instr_done,     // last cycle
  input wire logic        exec_busy,      // running
  input wire logic        mem_we,         // stack write
  input wire logic        mem_re,         // stack read
  input wire logic        avs_read,       // bus read
  input wire logic        avs_write,      // bus write
  input wire logic [31:0] avs_readdata,   // bus data
  input wire logic        avs_waitrequest // bus wait
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic take;
  assign take = instr_valid && instr_ready && clk_en;
  sequence quiet4;
    (!mem_we && !mem_re)[*4];
  endsequence
  sequence push_step;
    !mem_we ##1 (mem_we && !mem_re);
  endsequence
  sequence pop_step;
    !mem_re ##1 (mem_re && !mem_we);
  endsequence
  idle_quiet_a: assert property (take && instr_opcode == 8'hFF |=> quiet4 ##0 instr_done)
    else $error("idle instruction timing or memory activity wrong");
  or_short_a: assert property (take && instr_opcode == 8'h42 |-> ##4 instr_done)
    else $error("short or length wrong");
  or_long_a: assert property (take && instr_opcode inside {8'h43, 8'h44, 8'h45, 8'h46}
    |=> (!instr_done)[*5] ##1 instr_done)
    else $error("long or length wrong");
  push_order_a: assert property (take && instr_opcode inside {8'h70, 8'h71}
    |=> push_step ##1 (!mem_we)[*5] ##1 instr_done)
    else $error("stack write sequence wrong");
  pop_order_a: assert property (take && instr_opcode inside {8'h50, 8'h51}
    |=> pop_step ##1 (!mem_re)[*5] ##1 instr_done)
    else $error("stack read sequence wrong");
  user_len_a: assert property (take && instr_opcode inside {8'h92, 8'h93, 8'h82}
    |=> (exec_busy && !mem_we && !mem_re)[*7] ##1 instr_done)
    else $error("user stack timing wrong");
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest && !exec_busy
    && clk_en |=> !avs_waitrequest)
    else $error("register access not answered");
  read_upper_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  done_single_a: assert property (instr_done |=> !instr_done && !exec_busy)
    else $error("done not a single pulse");
endmodule : cose_exec_chk

bind cose_exec cose_exec_chk u_chk (.core_clk, .rst_b, .clk_en, .instr_valid, .instr_ready,
  .instr_opcode, .instr_done, .exec_busy, .mem_we, .mem_re, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest);

`default_nettype wire

// *** bench/testbench.sv ***
// self-checking bench for the or / stack execution block
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic        core_clk, rst_b, clk_en, instr_valid, instr_ready, instr_done, exec_busy;
  logic [7:0]  instr_opcode, instr_byte1, instr_byte2, mem_wdata, mem_rdata, avs_address, q;
  logic        mem_we, mem_re, avs_read, avs_write, avs_waitrequest;
  logic [15:0] mem_addr;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic [7:0]  ram [0:65535];
  int          err_total = 0, check_count = 0, cyc = 0;

  cose_exec uut (.core_clk, .rst_b, .clk_en, .instr_valid, .instr_ready, .instr_opcode,
    .instr_byte1, .instr_byte2, .instr_done, .exec_busy, .mem_addr, .mem_wdata, .mem_we,
    .mem_re, .mem_rdata, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // stack ram, one cycle read latency; unread data toggles so data sampled one cycle late does not match
  always @(posedge core_clk) begin
    cyc++;
    if (mem_we) ram[mem_addr] <= mem_wdata;
    mem_rdata <= mem_re ? ram[mem_addr] : ~mem_rdata;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    @(posedge core_clk);
    avs_read       <= ~wr;
    avs_write      <= wr;
    avs_address    <= a;
    avs_writedata  <= {24'h0, d};
    avs_byteenable <= be;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 4'hF);
    chk(nm, exp, q);
  endtask : rc

  task automatic run(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2);
    @(posedge core_clk);
    instr_valid  <= 1'b1;
    instr_opcode <= op;
    instr_byte1  <= b1;
    instr_byte2  <= b2;
    do @(posedge core_clk); while (instr_ready !== 1'b1);
    instr_valid <= 1'b0;
    do @(posedge core_clk); while (instr_done !== 1'b1);
  endtask : run

  // all flags preset, so kept and cleared bits both show
  task automatic or_case(input logic [7:0] op, b1, b2, d, dv, s, sv, p, pv, res);
    wr(8'hD5, 8'hFF);
    wr(s, sv);
    wr(p, pv);
    wr(d, dv);
    run(op, b1, b2);
    rc("or result", d, res);
    rc("or source", p, pv);
    rc("or flags", 8'hD5, {1'b1, res == 8'h00, res[7], 1'b0, 4'hF});
  endtask : or_case

  initial begin
    rst_b          = 1'b0;
    clk_en         = 1'b1;
    instr_valid    = 1'b0;
    instr_opcode   = 8'h00;
    instr_byte1    = 8'h00;
    instr_byte2    = 8'h00;
    mem_rdata      = 8'h00;
    avs_address    = 8'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'h0;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    rc("sp high reset", 8'hD8, 8'h00);
    rc("sp low reset", 8'hD9, 8'h00);
    wr(8'hD8, 8'h12);
    bus(1'b1, 8'hD8, 8'h77, 4'hE);
    rc("sp high", 8'hD8, 8'h12);
    or_case(8'h42, 8'h01, 8'h00, 8'hC0, 8'h15, 8'hC1, 8'h2A, 8'hC1, 8'h2A, 8'h3F);
    or_case(8'h43, 8'h02, 8'h00, 8'hC0, 8'h00, 8'hC2, 8'h10, 8'h10, 8'h80, 8'h80);
    or_case(8'h44, 8'h20, 8'h21, 8'h21, 8'h00, 8'h20, 8'h00, 8'h20, 8'h00, 8'h00);
    or_case(8'h44, 8'h26, 8'h27, 8'h27, 8'h08, 8'h26, 8'h41, 8'h26, 8'h41, 8'h49);
    or_case(8'h45, 8'h22, 8'h23, 8'h23, 8'hF0, 8'h22, 8'h30, 8'h30, 8'h0F, 8'hFF);
    or_case(8'h46, 8'h24, 8'h02, 8'h24, 8'h08, 8'h25, 8'h77, 8'h25, 8'h77, 8'h0A);
    wr(8'hD5, 8'h5A);
    run(8'hFF, 8'h24, 8'h00);
    rc("idle flags", 8'hD5, 8'hA5 ^ 8'hFF);
    rc("idle reg", 8'h24, 8'h0A);
    wr(8'hD8, 8'h00);
    wr(8'hD9, 8'h00);
    wr(8'hD5, 8'hA5);
    wr(8'h40, 8'h4F);
    wr(8'h4F, 8'hAA);
    run(8'h70, 8'h40, 8'h00);
    chk("push data", 8'h4F, ram[16'hFFFF]);
    rc("sp high wrap", 8'hD8, 8'hFF);
    rc("sp low wrap", 8'hD9, 8'hFF);
    run(8'h71, 8'h40, 8'h00);
    chk("push ind data", 8'hAA, ram[16'hFFFE]);
    rc("sp low push", 8'hD9, 8'hFE);
    run(8'h50, 8'h41, 8'h00);
    rc("pop reg", 8'h41, 8'hAA);
    rc("sp low pop", 8'hD9, 8'hFF);
    wr(8'h42, 8'h43);
    run(8'h51, 8'h42, 8'h00);
    rc("pop ind", 8'h43, 8'h4F);
    rc("sp high up", 8'hD8, 8'h00);
    rc("sp low up", 8'hD9, 8'h00);
    rc("stack flags", 8'hD5, 8'hA5);
    wr(8'h00, 8'h42);
    wr(8'h42, 8'h6F);
    wr(8'h02, 8'h70);
    run(8'h92, 8'h00, 8'h02);
    rc("desc read dst", 8'h02, 8'h6F);
    rc("desc read ptr", 8'h00, 8'h41);
    wr(8'h00, 8'h01);
    wr(8'h01, 8'h70);
    run(8'h93, 8'h00, 8'h02);
    rc("asc read dst", 8'h02, 8'h70);
    rc("asc read ptr", 8'h00, 8'h02);
    wr(8'h00, 8'h03);
    wr(8'h01, 8'h05);
    wr(8'h02, 8'h1A);
    run(8'h82, 8'h00, 8'h01);
    rc("desc write ptr", 8'h00, 8'h02);
    rc("desc write data", 8'h02, 8'h05);
    rc("desc write src", 8'h01, 8'h05);
    rc("user flags", 8'hD5, 8'hA5);
    print_verdict();
  end
endmodule : testbench

`default_nettype wire
